// ---- rtl/dpq_consts.svh ----
// Purpose: shared numbers of the pdu qos mapper, both link ends
// Assumes: 100 MHz clock on both ends
// Notes: times in ms, cycle counts derived in the top modules
`ifndef DPQ_CONSTS_SVH
`define DPQ_CONSTS_SVH
`define DPQ_PDU_LAST 6'h32
`define DPQ_SEG_PAY 6'h31
`define DPQ_CELL_HEC_IDX 6'h04
`define DPQ_CLID_CELL 3'h1
`define DPQ_CLID_PKT 3'h2
`define DPQ_CLK_KHZ 100000
`define DPQ_PTD_MS 5
`define DPQ_PDV_MS 5
`define DPQ_ARQ_MIN_MS 3
`define DPQ_CONN_N 4
`define DPQ_SIG_CONN 2'h0
`define DPQ_FIFO_DEPTH 16
`define DPQ_TS_W 20
`define DPQ_LEN_W 16
`endif

// ---- rtl/dpq_pkg.sv ----
// Purpose: types shared by both link ends
// Assumes: dpq_consts.svh widths
// Notes: one link word carries one pdu byte plus its sideband
`include "dpq_consts.svh"
package dpq_pkg;
  // ---------------------------------------------------------------
  // categories, identifiers, link word
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    periodic_real_time_class,
    real_time_class,
    non_real_time_class,
    best_effort_class
  } dpq_cat_t;
  typedef logic [2:0] dpq_clid_t;
  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
    dpq_clid_t clid;
    dpq_cat_t cat;
    logic [1:0] conn;
    logic arq;
    logic [`DPQ_TS_W-1:0] stamp;
  } dpq_word_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_HDR,
    ST_BODY,
    ST_PAD,
    ST_DRAIN
  } dpq_tx_state_t;
endpackage : dpq_pkg

// ---- rtl/dpq_link_if.sv ----
// Purpose: byte link between the mapper end and the peer end
// Assumes: both ends on clk_i
// Notes: valid/ready handshake, one word per cycle
`timescale 1ns/1ps
interface dpq_link_if;
  import dpq_pkg::*;
  logic valid;
  logic ready;
  dpq_word_t word;
  modport sender(output valid, output word, input ready);
  modport receiver(input valid, input word, output ready);
endinterface : dpq_link_if

// ---- rtl/dpq_fifo.sv ----
// Purpose: small valid/ready fifo
// Assumes: DEPTH a power of two
// Notes: extra pointer bit separates full from empty
`timescale 1ns/1ps
module dpq_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // fill side
  input wire logic wr_valid_i,
  input wire logic [W-1:0] wr_data_i,
  output logic wr_ready_o,
  // drain side
  output logic rd_valid_o,
  output logic [W-1:0] rd_data_o,
  input wire logic rd_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic wr_go;
  logic rd_go;

  assign wr_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign rd_valid_o = (wr_ptr != rd_ptr);
  assign rd_data_o = mem[rd_ptr[AW-1:0]];

  always_comb begin
    wr_go = wr_valid_i && wr_ready_o;
    rd_go = rd_valid_o && rd_ready_i;
    next_wr_ptr = wr_go ? wr_ptr + (AW+1)'(1) : wr_ptr;
    next_rd_ptr = rd_go ? rd_ptr + (AW+1)'(1) : rd_ptr;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage has no reset; nothing reads a slot before it is written
  always_ff @(posedge clk_i) begin
    if (wr_go) begin
      mem[wr_ptr[AW-1:0]] <= wr_data_i;
    end
  end
endmodule : dpq_fifo

// ---- rtl/dpq_dev_end.sv ----
// Purpose: maps convergence layer cells and packets onto fixed pdus
// Assumes: convergence layer holds clid and length through a frame
// Notes: pdus leave through a 16-word fifo onto the link
//
// Contract
// - layer id 0..7, 1 cell, 2 packet
// - every pdu is exactly 51 bytes
// - one cell per pdu, drop check/path fields
// - cell header shortened to three bytes
// - packets segmented on send, reassembled on receive
// - each connection in one of four categories
// - top two categories bounded 5 ms delay
// - retransmission minimum 3 ms within maximum delay
// - no bounded pdu exceeds maximum transfer delay; the code only flags a late pdu on late_o
// - order kept, no pdu before connection open
// - retransmission only uplink, set per connection
// - uplink delay shares sum within system maximum; the code does not check this
// - qos taken per connection, grouped here
// - looser limits allowed, tighter ones not
// - category codes 0 to 3 in order
// - signalling connection never retransmitted
`timescale 1ns/1ps
`include "dpq_consts.svh"
module dpq_dev_end
  import dpq_pkg::*;
#(
  parameter int unsigned PTD_CYC = `DPQ_PTD_MS * `DPQ_CLK_KHZ,
  parameter int unsigned ARQ_MIN_CYC = `DPQ_ARQ_MIN_MS * `DPQ_CLK_KHZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // per-connection setup
  input wire logic cfg_we_i,
  input wire logic [1:0] cfg_conn_i,
  input wire dpq_cat_t cfg_cat_i,
  input wire logic cfg_arq_i,
  input wire logic cfg_open_i,
  input wire logic [`DPQ_TS_W-1:0] cfg_limit_i,
  input wire logic uplink_i,
  output logic cfg_err_o,
  // convergence layer
  input wire logic [`DPQ_CONN_N-1:0] req_i,
  output logic [`DPQ_CONN_N-1:0] grant_o,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [7:0] in_data_i,
  input wire logic in_last_i,
  input wire dpq_clid_t in_clid_i,
  input wire logic [`DPQ_LEN_W-1:0] in_len_i,
  // status
  output logic late_o,
  output logic refused_o,
  // link
  dpq_link_if.sender link
);
  localparam logic [`DPQ_TS_W-1:0] PTD_LIM = `DPQ_TS_W'(PTD_CYC);
  localparam logic [`DPQ_TS_W-1:0] ARQ_LIM = `DPQ_TS_W'(ARQ_MIN_CYC);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  dpq_tx_state_t state, next_state;
  logic [1:0] conn, next_conn;
  dpq_clid_t clid, next_clid;
  dpq_cat_t cat, next_cat;
  logic arq, next_arq;
  logic [`DPQ_TS_W-1:0] stamp, next_stamp, now, next_now;
  logic [5:0] out_cnt, next_out_cnt, in_cnt, next_in_cnt, seg_left, next_seg_left;
  logic [`DPQ_LEN_W-1:0] rem, next_rem;
  logic first_seg, next_first_seg, done, next_done;
  logic [3:0] gfc, next_gfc;
  logic late, next_late, cfg_err, next_cfg_err;
  dpq_cat_t cat_tab [`DPQ_CONN_N];
  logic [`DPQ_TS_W-1:0] lim_tab [`DPQ_CONN_N];
  logic [`DPQ_CONN_N-1:0] arq_tab, open_tab;
  logic found;
  logic [1:0] sel;
  logic push, fifo_ready, take, seg_last, end_pdu, is_cell;
  logic [5:0] seg_len;
  dpq_word_t push_word;
  logic [$bits(dpq_word_t)-1:0] pop_raw;

  // ---------------------------------------------------------------
  // connection selector
  // ---------------------------------------------------------------
  // last match wins, so lowest category then lowest connection
  always_comb begin
    found = 1'b0;
    sel = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      for (int i = `DPQ_CONN_N - 1; i >= 0; i--) begin
        if (req_i[i] && open_tab[i] && (2'(cat_tab[i]) == 2'(k))) begin
          found = 1'b1;
          sel = 2'(i);
        end
      end
    end
  end

  assign refused_o = |(req_i & ~open_tab);
  assign grant_o = (state == ST_IDLE) ? '0 : `DPQ_CONN_N'(1) << conn;
  assign is_cell = (clid == `DPQ_CLID_CELL);
  assign seg_last = (rem <= {10'h000, `DPQ_SEG_PAY});
  assign seg_len = seg_last ? rem[5:0] : `DPQ_SEG_PAY;

  // ---------------------------------------------------------------
  // framer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_conn = conn;
    next_clid = clid;
    next_cat = cat;
    next_arq = arq;
    next_stamp = stamp;
    next_out_cnt = out_cnt;
    next_in_cnt = in_cnt;
    next_seg_left = seg_left;
    next_rem = rem;
    next_first_seg = first_seg;
    next_done = done;
    next_gfc = gfc;
    in_ready_o = 1'b0;
    push = 1'b0;
    end_pdu = 1'b0;
    push_word = '0;
    push_word.clid = clid;
    push_word.cat = cat;
    push_word.conn = conn;
    push_word.arq = arq;
    push_word.stamp = stamp;
    push_word.first = (out_cnt == 6'h00);
    push_word.last = (out_cnt == `DPQ_PDU_LAST);
    take = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (found) begin
          next_conn = sel;
          next_cat = cat_tab[sel];
          next_arq = arq_tab[sel] && uplink_i && (sel != `DPQ_SIG_CONN);
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (in_valid_i) begin
          next_clid = in_clid_i;
          next_rem = in_len_i;
          next_stamp = now;
          next_in_cnt = 6'h00;
          next_out_cnt = 6'h00;
          next_first_seg = 1'b1;
          next_done = 1'b0;
          next_state = (in_clid_i == `DPQ_CLID_CELL) ? ST_BODY : ST_HDR;
        end
      end
      ST_HDR: begin
        push = 1'b1;
        push_word.data = (out_cnt == 6'h00) ? {first_seg, seg_last, 6'h00} : {2'h0, seg_len};
        if (fifo_ready) begin
          next_out_cnt = out_cnt + 6'h01;
          if (out_cnt == 6'h01) begin
            next_seg_left = seg_len;
            next_state = (seg_len == 6'h00) ? ST_PAD : ST_BODY;
          end
        end
      end
      ST_BODY: begin
        in_ready_o = fifo_ready;
        take = in_valid_i && fifo_ready;
        if (is_cell) begin
          // path id and header check are consumed but never sent
          push = take && (in_cnt != 6'h00) && (in_cnt != `DPQ_CELL_HEC_IDX);
          push_word.data = (in_cnt == 6'h01) ? {gfc, in_data_i[3:0]} : in_data_i;
        end else begin
          push = take;
          push_word.data = in_data_i;
        end
        if (take) begin
          next_in_cnt = in_cnt + 6'h01;
          if (in_cnt == 6'h00) begin
            next_gfc = in_data_i[7:4];
          end
          if (!is_cell) begin
            next_rem = rem - 16'h0001;
            next_seg_left = seg_left - 6'h01;
          end
          if (push) begin
            next_out_cnt = out_cnt + 6'h01;
            end_pdu = (out_cnt == `DPQ_PDU_LAST);
          end
          if (in_last_i) begin
            next_done = 1'b1;
            next_state = end_pdu ? ST_IDLE : ST_PAD;
          end else if (end_pdu) begin
            next_state = (is_cell || (rem == 16'h0001)) ? ST_DRAIN : ST_HDR;
            next_out_cnt = 6'h00;
            next_first_seg = 1'b0;
          end else if (!is_cell && (seg_left == 6'h01)) begin
            next_state = ST_PAD;
          end
        end
      end
      ST_PAD: begin
        push = 1'b1;
        push_word.data = 8'h00;
        if (fifo_ready) begin
          next_out_cnt = out_cnt + 6'h01;
          if (out_cnt == `DPQ_PDU_LAST) begin
            next_state = done ? ST_IDLE : ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        in_ready_o = 1'b1;
        if (in_valid_i && in_last_i) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // bounded categories checked as the last byte leaves
  always_comb begin
    next_now = now + `DPQ_TS_W'(1);
    next_late = link.valid && link.ready && link.word.last
                && (2'(link.word.cat) <= 2'(real_time_class))
                && ((now - link.word.stamp) > lim_tab[link.word.conn]);
    // retransmission needs room for its minimum delay below the limit
    next_cfg_err = cfg_we_i && ((cfg_limit_i < PTD_LIM)
                   || (cfg_arq_i && (cfg_limit_i <= ARQ_LIM)));
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      conn <= 2'h0;
      clid <= 3'h0;
      cat <= best_effort_class;
      arq <= 1'b0;
      stamp <= '0;
      now <= '0;
      out_cnt <= 6'h00;
      in_cnt <= 6'h00;
      seg_left <= 6'h00;
      rem <= 16'h0000;
      first_seg <= 1'b0;
      done <= 1'b0;
      gfc <= 4'h0;
      late <= 1'b0;
      cfg_err <= 1'b0;
    end else begin
      state <= next_state;
      conn <= next_conn;
      clid <= next_clid;
      cat <= next_cat;
      arq <= next_arq;
      stamp <= next_stamp;
      now <= next_now;
      out_cnt <= next_out_cnt;
      in_cnt <= next_in_cnt;
      seg_left <= next_seg_left;
      rem <= next_rem;
      first_seg <= next_first_seg;
      done <= next_done;
      gfc <= next_gfc;
      late <= next_late;
      cfg_err <= next_cfg_err;
    end
  end

  // ---------------------------------------------------------------
  // per-connection table
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arq_tab <= '0;
      open_tab <= '0;
      for (int i = 0; i < `DPQ_CONN_N; i++) begin
        cat_tab[i] <= best_effort_class;
        lim_tab[i] <= PTD_LIM;
      end
    end else if (cfg_we_i) begin
      cat_tab[cfg_conn_i] <= cfg_cat_i;
      arq_tab[cfg_conn_i] <= cfg_arq_i && (cfg_conn_i != `DPQ_SIG_CONN);
      open_tab[cfg_conn_i] <= cfg_open_i;
      lim_tab[cfg_conn_i] <= (cfg_limit_i < PTD_LIM) ? PTD_LIM : cfg_limit_i;
    end
  end

  assign late_o = late;
  assign cfg_err_o = cfg_err;

  // ---------------------------------------------------------------
  // output buffer, single queue keeps pdu order
  // ---------------------------------------------------------------
  dpq_fifo #(
    .W($bits(dpq_word_t)),
    .DEPTH(`DPQ_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_valid_i(push),
    .wr_data_i(push_word),
    .wr_ready_o(fifo_ready),
    .rd_valid_o(link.valid),
    .rd_data_o(pop_raw),
    .rd_ready_i(link.ready)
  );
  assign link.word = dpq_word_t'(pop_raw);
endmodule : dpq_dev_end

// ---- rtl/dpq_peer_end.sv ----
// Purpose: peer end, takes pdus off the link and delivers upward
// Assumes: released from reset together with the mapper end
// Notes: local time counter matches the sender's stamps
`timescale 1ns/1ps
`include "dpq_consts.svh"
module dpq_peer_end
  import dpq_pkg::*;
#(
  parameter int unsigned PTD_CYC = `DPQ_PTD_MS * `DPQ_CLK_KHZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // link
  dpq_link_if.receiver link,
  // connections open at this end
  input wire logic [`DPQ_CONN_N-1:0] open_i,
  // upward delivery
  output logic up_valid_o,
  input wire logic up_ready_i,
  output logic [7:0] up_data_o,
  output logic up_last_o,
  output logic [1:0] up_conn_o,
  output dpq_clid_t up_clid_o,
  // status
  output logic late_o,
  output logic len_err_o,
  output logic drop_o
);
  localparam logic [`DPQ_TS_W-1:0] PTD_LIM = `DPQ_TS_W'(PTD_CYC);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [`DPQ_TS_W-1:0] now, next_now;
  logic [5:0] idx, next_idx, seg_len, next_seg_len, idx_cur, pay;
  logic seg_end, next_seg_end, drop_cur, next_drop_cur;
  logic up_valid, next_up_valid, up_last, next_up_last;
  logic [7:0] up_data, next_up_data;
  logic [1:0] up_conn, next_up_conn;
  dpq_clid_t up_clid, next_up_clid;
  logic late, next_late, len_err, next_len_err, drop, next_drop;
  logic take, skip, emit, last_up;
  dpq_word_t w;

  // ---------------------------------------------------------------
  // receive and reassemble
  // ---------------------------------------------------------------
  assign link.ready = !up_valid || up_ready_i;
  assign w = link.word;

  always_comb begin
    take = link.valid && link.ready;
    idx_cur = w.first ? 6'h00 : idx;
    pay = idx_cur - 6'h02;
    skip = w.first ? !open_i[w.conn] : drop_cur;
    next_now = now + `DPQ_TS_W'(1);
    next_idx = idx;
    next_seg_len = seg_len;
    next_seg_end = seg_end;
    next_drop_cur = drop_cur;
    next_up_valid = up_valid && !up_ready_i;
    next_up_data = up_data;
    next_up_last = up_last;
    next_up_conn = up_conn;
    next_up_clid = up_clid;
    next_late = 1'b0;
    next_len_err = 1'b0;
    next_drop = 1'b0;
    emit = 1'b0;
    last_up = 1'b0;
    if (take) begin
      next_idx = w.last ? 6'h00 : idx_cur + 6'h01;
      next_drop_cur = skip;
      if (w.clid == `DPQ_CLID_CELL) begin
        emit = !skip;
        last_up = (idx_cur == `DPQ_PDU_LAST);
      end else begin
        if (idx_cur == 6'h00) begin
          next_seg_end = w.data[6];
        end
        if (idx_cur == 6'h01) begin
          next_seg_len = w.data[5:0];
        end
        emit = !skip && (idx_cur >= 6'h02) && (pay < seg_len);
        last_up = seg_end && (pay == seg_len - 6'h01);
      end
      if (emit) begin
        next_up_valid = 1'b1;
        next_up_data = w.data;
        next_up_last = last_up;
        next_up_conn = w.conn;
        next_up_clid = w.clid;
      end
      // a frame cut short or run long shows at its last byte or next first
      next_len_err = (w.last && (idx_cur != `DPQ_PDU_LAST)) || (w.first && (idx != 6'h00));
      next_drop = w.last && skip;
      next_late = w.last && (2'(w.cat) <= 2'(real_time_class))
                  && ((now - w.stamp) > PTD_LIM);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      now <= '0;
      idx <= 6'h00;
      seg_len <= 6'h00;
      seg_end <= 1'b0;
      drop_cur <= 1'b0;
      up_valid <= 1'b0;
      up_data <= 8'h00;
      up_last <= 1'b0;
      up_conn <= 2'h0;
      up_clid <= 3'h0;
      late <= 1'b0;
      len_err <= 1'b0;
      drop <= 1'b0;
    end else begin
      now <= next_now;
      idx <= next_idx;
      seg_len <= next_seg_len;
      seg_end <= next_seg_end;
      drop_cur <= next_drop_cur;
      up_valid <= next_up_valid;
      up_data <= next_up_data;
      up_last <= next_up_last;
      up_conn <= next_up_conn;
      up_clid <= next_up_clid;
      late <= next_late;
      len_err <= next_len_err;
      drop <= next_drop;
    end
  end

  assign up_valid_o = up_valid;
  assign up_data_o = up_data;
  assign up_last_o = up_last;
  assign up_conn_o = up_conn;
  assign up_clid_o = up_clid;
  assign late_o = late;
  assign len_err_o = len_err;
  assign drop_o = drop;
endmodule : dpq_peer_end

// ---- verif/dpq_link_props.sv ----
// Purpose: link checks between the mapper end and the peer end
// Assumes: one clock, asynchronous low reset
// Notes: word index is counted here from accepted transfers
`timescale 1ns/1ps
module dpq_link_props
  import dpq_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // link
  input wire logic valid,
  input wire logic ready,
  input wire dpq_word_t word
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ---------------------------------------------------------------
  // word position within a pdu
  // ---------------------------------------------------------------
  logic acc;
  logic pkt;
  logic [5:0] idx;
  logic [5:0] next_idx;
  dpq_word_t head;
  dpq_word_t next_head;
  assign acc = valid & ready;
  assign pkt = word.clid != 3'h1;
  always_comb begin
    next_idx = idx;
    next_head = head;
    if (acc) begin
      next_idx = (idx == 6'h32) ? 6'h00 : idx + 6'h01;
      if (idx == 6'h00) next_head = word;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idx <= 6'h00;
      head <= '0;
    end else begin
      idx <= next_idx;
      head <= next_head;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_hold;
    valid && !ready |=> valid && $stable(word);
  endproperty
  a_hold: assert property (p_hold) else $error("link word moved before taken");
  property p_first_pos;
    acc && word.first |-> idx == 6'h00;
  endproperty
  a_first_pos: assert property (p_first_pos) else $error("first flag off position");
  property p_last_pos;
    acc && word.last |-> idx == 6'h32;
  endproperty
  a_last_pos: assert property (p_last_pos) else $error("last flag not at word 50");
  property p_first_req;
    acc && idx == 6'h00 |-> word.first && !word.last;
  endproperty
  a_first_req: assert property (p_first_req) else $error("pdu start not flagged");
  property p_next_first;
    acc && word.last |=> !valid || word.first;
  endproperty
  a_next_first: assert property (p_next_first) else $error("word after last not first");
  property p_sig_noarq;
    acc && word.conn == 2'h0 |-> !word.arq;
  endproperty
  a_sig_noarq: assert property (p_sig_noarq) else $error("signalling word marked arq");
  property p_same_pdu;
    acc && idx != 6'h00 |-> word.conn == head.conn && word.cat == head.cat && word.clid == head.clid;
  endproperty
  a_same_pdu: assert property (p_same_pdu) else $error("pdu mixes connections");
  property p_seg_flags;
    acc && idx == 6'h00 && pkt |-> word.data[5:0] == 6'h00;
  endproperty
  a_seg_flags: assert property (p_seg_flags) else $error("segment header spare bits set");
  property p_seg_len;
    acc && idx == 6'h01 && pkt |-> word.data <= 8'h31;
  endproperty
  a_seg_len: assert property (p_seg_len) else $error("segment length above 49");
  c_cell: cover property (acc && word.last && !pkt);
  c_pkt: cover property (acc && word.last && pkt);
  c_stall: cover property ((valid && !ready) [*3]);
endmodule : dpq_link_props

// ---- verif/dlc_pdu_qos_mapper_tb.sv ----
// Purpose: end-to-end bench, mapper end facing peer end
// Assumes: short delay limits set through parameters
// Notes: link bytes and upward packet bytes gathered in queues
`timescale 1ns/1ps
`include "dpq_consts.svh"
module dlc_pdu_qos_mapper_tb;
  import dpq_pkg::*;
  localparam int unsigned PDU_TRANSFER_DELAY = 200;
  logic clk_i, arst_n_i, cfg_we, cfg_arq, cfg_open, uplink, cfg_err, in_valid, in_ready, in_last;
  logic d_late, refused, up_valid, up_ready, up_last, p_late, len_err, drop, arq_seen;
  logic [1:0] cfg_conn, up_conn;
  logic [3:0] req, grant, open_p;
  logic [7:0] in_data, up_data;
  logic [`DPQ_TS_W-1:0] cfg_limit;
  logic [15:0] in_len;
  dpq_cat_t cfg_cat;
  dpq_clid_t in_clid, up_clid;
  int n_mismatch = 0, check_count = 0, late_n = 0, plate_n = 0, drop_n = 0, lerr_n = 0;
  logic [7:0] lq[$];
  logic [10:0] uq[$];
  // ---------------------------------------------------------------
  // both ends and the link
  // ---------------------------------------------------------------
  dpq_link_if i_dpq_link_if ();
  dpq_dev_end #(.PTD_CYC(PDU_TRANSFER_DELAY), .ARQ_MIN_CYC(100)) i_dpq_dev_end (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .cfg_we_i(cfg_we), .cfg_conn_i(cfg_conn), .cfg_cat_i(cfg_cat), .cfg_arq_i(cfg_arq), .cfg_open_i(cfg_open),
    .cfg_limit_i(cfg_limit), .uplink_i(uplink), .cfg_err_o(cfg_err), .req_i(req), .grant_o(grant),
    .in_valid_i(in_valid), .in_ready_o(in_ready), .in_data_i(in_data), .in_last_i(in_last),
    .in_clid_i(in_clid), .in_len_i(in_len), .late_o(d_late), .refused_o(refused), .link(i_dpq_link_if));
  dpq_peer_end #(.PTD_CYC(PDU_TRANSFER_DELAY)) i_dpq_peer_end (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(i_dpq_link_if),
    .open_i(open_p), .up_valid_o(up_valid), .up_ready_i(up_ready), .up_data_o(up_data), .up_last_o(up_last),
    .up_conn_o(up_conn), .up_clid_o(up_clid), .late_o(p_late), .len_err_o(len_err), .drop_o(drop));
  dpq_link_props i_dpq_link_props (.clk_i(clk_i), .arst_n_i(arst_n_i), .valid(i_dpq_link_if.valid),
    .ready(i_dpq_link_if.ready), .word(i_dpq_link_if.word));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (i_dpq_link_if.valid && i_dpq_link_if.ready) lq.push_back(i_dpq_link_if.word.data);
    if (i_dpq_link_if.valid && i_dpq_link_if.ready) arq_seen = i_dpq_link_if.word.arq;
    if (up_valid && up_ready && up_clid != 3'h1) uq.push_back({up_conn, up_last, up_data});
    late_n += d_late;
    plate_n += p_late;
    drop_n += drop;
    lerr_n += len_err;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic cfg(input logic [1:0] c, input dpq_cat_t k, input logic a, input logic o,
                     input logic [`DPQ_TS_W-1:0] l, input logic e);
    {cfg_conn, cfg_arq, cfg_open, cfg_limit, cfg_we} = {c, a, o, l, 1'b1};
    cfg_cat = k;
    @(posedge clk_i);
    #1;
    cfg_we = 1'b0;
    chk(cfg_err, e);
    @(posedge clk_i);
    #1;
  endtask : cfg
  task automatic send(input logic [1:0] c, input dpq_clid_t cl, input int n);
    int i;
    logic r;
    i = 0;
    req[c] = 1'b1;
    for (int w = 0; w < 20 && grant === 4'h0; w++) begin
      @(posedge clk_i);
      #1;
    end
    chk(grant, 4'h1 << c);
    {in_valid, in_clid, in_len} = {1'b1, cl, 16'(n)};
    while (i < n) begin
      in_data = 8'h1F + 8'(i);
      in_last = (i == n - 1);
      @(negedge clk_i);
      r = in_ready;
      @(posedge clk_i);
      #1;
      if (r) i++;
    end
    {in_valid, in_last} = 2'b00;
    req[c] = 1'b0;
  endtask : send
  // far side refuses for a while so the fifo fills before draining
  task automatic stall(input logic [1:0] c, input dpq_clid_t cl, input int n);
    up_ready = 1'b0;
    fork
      send(c, cl, n);
      begin
        repeat (300) @(posedge clk_i);
        #1;
        chk(in_ready, 1'b0);
        up_ready = 1'b1;
      end
    join
  endtask : stall
  task automatic wait_q(input int n);
    for (int i = 0; i < 600 && lq.size() < n; i++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    #1;
    chk(lq.size(), n);
  endtask : wait_q
  task automatic chk_cell;
    chk(lq.pop_front(), 8'h10);
    chk(lq.pop_front(), 8'h21);
    chk(lq.pop_front(), 8'h22);
    for (int k = 3; k < 51; k++) chk(lq.pop_front(), 8'h21 + 8'(k));
  endtask : chk_cell
  task automatic chk_pkt(input int n);
    int s;
    int k;
    s = 0;
    while (s < n) begin
      k = (n - s > 49) ? 49 : n - s;
      chk(lq.pop_front(), {s == 0, s + k == n, 6'h00});
      chk(lq.pop_front(), k);
      for (int j = 0; j < 49; j++) chk(lq.pop_front(), (j < k) ? 8'h1F + 8'(s + j) : 8'h00);
      s += k;
    end
  endtask : chk_pkt
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {cfg_we, cfg_arq, cfg_open, in_valid, in_last, arst_n_i, cfg_conn, req} = '0;
    {cfg_limit, in_data, in_len, in_clid} = '0;
    cfg_cat = best_effort_class;
    {uplink, up_ready, open_p} = {1'b1, 1'b1, 4'h7};
    repeat (10) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    cfg(2'h0, best_effort_class, 1'b1, 1'b1, 20'h0012C, 1'b0);
    cfg(2'h1, periodic_real_time_class, 1'b0, 1'b1, 20'h00064, 1'b1);
    cfg(2'h2, non_real_time_class, 1'b1, 1'b1, 20'h00064, 1'b1);
    cfg(2'h2, non_real_time_class, 1'b1, 1'b1, 20'h000FA, 1'b0);
    cfg(2'h3, real_time_class, 1'b0, 1'b0, 20'h000C8, 1'b0);
    $display("test config done");
    req = 4'h3;
    @(posedge clk_i);
    #1;
    send(2'h1, 3'h1, 53);
    send(2'h0, 3'h1, 53);
    wait_q(102);
    chk_cell();
    chk_cell();
    $display("test cell priority done");
    stall(2'h2, 3'h2, 60);
    wait_q(102);
    chk_pkt(60);
    chk(arq_seen, 1'b1);
    chk(uq.size(), 60);
    for (int i = 0; i < 60; i++) chk(uq.pop_front(), {2'h2, i == 59, 8'h1F + 8'(i)});
    chk(late_n, 0);
    $display("test packet stall done");
    for (int c = 1; c >= 0; c--) begin
      stall(2'(c), 3'h1, 53);
      wait_q(51);
      chk_cell();
      chk(late_n, 1);
      chk(plate_n, 1);
    end
    $display("test late done");
    req = 4'h8;
    repeat (4) @(posedge clk_i);
    #1;
    chk(refused, 1'b1);
    chk(grant, 4'h0);
    req = 4'h0;
    cfg(2'h3, real_time_class, 1'b1, 1'b1, 20'h000C8, 1'b0);
    uplink = 1'b0;
    send(2'h3, 3'h7, 10);
    wait_q(51);
    chk_pkt(10);
    chk(arq_seen, 1'b0);
    chk(drop_n, 1);
    chk(uq.size(), 0);
    chk(lerr_n, 0);
    $display("test closed connection done");
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
  end
endmodule : dlc_pdu_qos_mapper_tb
